// ---- rtl/hop_pkg.sv ----
package hop_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CP_W = 4;
  localparam int VA_W = 5;
  localparam int VC_W = 6;
  localparam int FREQ_W = 24;
  localparam int CHAN_W = 4;
  localparam logic [6:0] ADDR_MAIN = 7'h00;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h02;
  localparam logic [6:0] ADDR_SET_A = 7'h04;
  localparam logic [6:0] ADDR_SET_B = 7'h08;
  localparam logic [6:0] ADDR_SET_END = 7'h0B;
  localparam logic [6:0] ADDR_CALIBRATE = 7'h1B;
  localparam logic [6:0] ADDR_PA_POWER = 7'h1C;
  localparam logic [6:0] ADDR_OVR_CP = 7'h21;
  localparam logic [6:0] ADDR_OVR_VA = 7'h22;
  localparam logic [6:0] ADDR_OVR_VC = 7'h23;
  localparam logic [6:0] ADDR_STATUS = 7'h40;
  localparam logic [6:0] ADDR_RES_CP = 7'h45;
  localparam logic [6:0] ADDR_RES_VA = 7'h46;
  localparam logic [6:0] ADDR_RES_VC = 7'h47;
  localparam logic [1:0] SET_HI = 2'h0;
  localparam logic [1:0] SET_MID = 2'h1;
  localparam logic [1:0] SET_LO = 2'h2;
  localparam logic [1:0] SET_CLK = 2'h3;
  localparam int MAIN_RXTX_BIT = 7;
  localparam int MAIN_SEL_BIT = 6;
  localparam int SOFT_RESET_BIT = 0;
  localparam int CAL_START_BIT = 7;
  localparam int OVR_VA_EN_BIT = 5;
  localparam int OVR_CP_EN_BIT = 6;
  localparam int OVR_VC_EN_BIT = 6;
  localparam int STATUS_CAL_DONE_BIT = 7;
  localparam int STATUS_LOCK_BIT = 4;
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_FREQ = 8'h00;
  localparam logic [7:0] RST_CAL = 8'h00;
  localparam logic [7:0] RST_PA = 8'h00;
  localparam logic [7:0] RST_OVR = 8'h00;
  localparam logic [7:0] POLL_LIMIT = 8'hFF;

  typedef enum logic [1:0] {
    OP_WR = 2'b00,
    OP_RD = 2'b01,
    OP_POLL = 2'b10,
    OP_END = 2'b11
  } op_kind_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN = 2'b01,
    HS_WAIT = 2'b10
  } host_state_e;
endpackage

// ---- rtl/hop_cfg_if.sv ----
`timescale 1ns/1ns
interface hop_cfg_if (
  input wire logic clk_sys
);
  logic wr_en;
  logic rd_en;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_valid;

  modport device (
    input wr_en,
    input rd_en,
    input addr,
    input wdata,
    output rdata,
    output rd_valid
  );

  modport host (
    output wr_en,
    output rd_en,
    output addr,
    output wdata,
    input rdata,
    input rd_valid
  );
endinterface

// ---- rtl/hop_device.sv ----
`timescale 1ns/1ns
// Operation
// - Two frequency sets; idle set stays writable.
// - Writing channel-select bit swaps synthesizer set.
// - Select 0 picks set A, 1 picks B.
// - Host calibrates each channel, stores three results.
// - Override fields and enables at fixed bits.
// - Calibration current result shared by all channels.
// - Host writes select first, then overrides.
// - Host mutes amplifier during hop, checks lock.
// - Host clears override enables before calibrating.
// - Every configuration register is eight bits.
// - Programmed reset restores all configuration defaults.
module hop_device import hop_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  hop_cfg_if.device bus,
  input wire logic cal_done_in,
  input wire logic lock_in,
  input wire logic [CP_W-1:0] cp_result_in,
  input wire logic [VA_W-1:0] va_result_in,
  input wire logic [VC_W-1:0] vc_result_in,
  output logic [FREQ_W-1:0] active_freq,
  output logic [7:0] active_clock,
  output logic rx_tx,
  output logic cal_start,
  output logic [7:0] pa_level,
  output logic [CP_W-1:0] cp_use,
  output logic [VA_W-1:0] va_use,
  output logic [VC_W-1:0] vc_use
);
  logic [7:0] main_reg;
  logic [7:0] set_reg [0:1][0:3];
  logic [7:0] cal_reg;
  logic [7:0] pa_reg;
  logic [7:0] ovr_cp_reg;
  logic [7:0] ovr_va_reg;
  logic [7:0] ovr_vc_reg;
  logic [CP_W-1:0] res_cp_reg;
  logic [VA_W-1:0] res_va_reg;
  logic [VC_W-1:0] res_vc_reg;
  logic cal_done_reg;
  logic cal_start_reg;
  logic [2:0] done_sync_reg;
  logic [1:0] lock_sync_reg;
  logic [7:0] rdata_reg;
  logic rd_valid_reg;
  logic [FREQ_W-1:0] freq_out_reg;
  logic [7:0] clock_out_reg;
  logic [CP_W-1:0] cp_use_reg;
  logic [VA_W-1:0] va_use_reg;
  logic [VC_W-1:0] vc_use_reg;
  logic [7:0] rd_mux;

  wire wr_main = bus.wr_en && (bus.addr == ADDR_MAIN);
  wire wr_cal = bus.wr_en && (bus.addr == ADDR_CALIBRATE);
  wire wr_pa = bus.wr_en && (bus.addr == ADDR_PA_POWER);
  wire wr_ovr_cp = bus.wr_en && (bus.addr == ADDR_OVR_CP);
  wire wr_ovr_va = bus.wr_en && (bus.addr == ADDR_OVR_VA);
  wire wr_ovr_vc = bus.wr_en && (bus.addr == ADDR_OVR_VC);
  wire soft_rst = bus.wr_en && (bus.addr == ADDR_SOFT_RESET) && bus.wdata[SOFT_RESET_BIT];
  wire cfg_clear = rst || (ce && soft_rst);
  wire set_hit = bus.wr_en && (bus.addr >= ADDR_SET_A) && (bus.addr <= ADDR_SET_END);
  wire set_idx = (bus.addr >= ADDR_SET_B);
  wire [1:0] byte_idx = bus.addr[1:0];
  wire sel = main_reg[MAIN_SEL_BIT];
  wire cal_go = ce && wr_cal && bus.wdata[CAL_START_BIT];
  wire done_rise = done_sync_reg[1] && !done_sync_reg[2];
  wire lock_now = lock_sync_reg[1];

  // Both sets are written freely; the selected one keeps feeding the synthesizer.
  always_ff @(posedge clk_sys) begin
    if (cfg_clear) begin
      main_reg <= RST_MAIN;
      cal_reg <= RST_CAL;
      pa_reg <= RST_PA;
      ovr_cp_reg <= RST_OVR;
      ovr_va_reg <= RST_OVR;
      ovr_vc_reg <= RST_OVR;
      for (int s = 0; s < 2; s++) begin
        for (int b = 0; b < 4; b++) begin
          set_reg[s][b] <= RST_FREQ;
        end
      end
    end else if (ce) begin
      if (wr_main) begin
        main_reg <= bus.wdata;
      end
      if (set_hit) begin
        set_reg[set_idx][byte_idx] <= bus.wdata;
      end
      if (wr_cal) begin
        cal_reg <= bus.wdata;
      end
      if (wr_pa) begin
        pa_reg <= bus.wdata;
      end
      if (wr_ovr_cp) begin
        ovr_cp_reg <= bus.wdata;
      end
      if (wr_ovr_va) begin
        ovr_va_reg <= bus.wdata;
      end
      if (wr_ovr_vc) begin
        ovr_vc_reg <= bus.wdata;
      end
    end
  end

  // The synchroniser first stage feeds only the second stage.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_sync_reg <= 3'h0;
      lock_sync_reg <= 2'h0;
    end else if (ce) begin
      done_sync_reg <= {done_sync_reg[1:0], cal_done_in};
      lock_sync_reg <= {lock_sync_reg[0], lock_in};
    end
  end

  // Results are quasi-static once the calibrator flags done, so they are
  // captured on the synchronised done edge rather than synchronised bit by bit.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      res_cp_reg <= '0;
      res_va_reg <= '0;
      res_vc_reg <= '0;
      cal_done_reg <= 1'b0;
      cal_start_reg <= 1'b0;
    end else if (ce) begin
      cal_start_reg <= cal_go;
      if (done_rise) begin
        res_cp_reg <= cp_result_in;
        res_va_reg <= va_result_in;
        res_vc_reg <= vc_result_in;
        cal_done_reg <= 1'b1;
      end else if (cal_go) begin
        cal_done_reg <= 1'b0;
      end
    end
  end

  wire [FREQ_W-1:0] freq_sel = sel ?
    {set_reg[1][SET_HI], set_reg[1][SET_MID], set_reg[1][SET_LO]} :
    {set_reg[0][SET_HI], set_reg[0][SET_MID], set_reg[0][SET_LO]};
  wire [7:0] clock_sel = sel ? set_reg[1][SET_CLK] : set_reg[0][SET_CLK];
  wire [CP_W-1:0] cp_next = ovr_va_reg[OVR_CP_EN_BIT] ? ovr_cp_reg[CP_W-1:0] :
    res_cp_reg;
  wire [VA_W-1:0] va_next = ovr_va_reg[OVR_VA_EN_BIT] ? ovr_va_reg[VA_W-1:0] :
    res_va_reg;
  wire [VC_W-1:0] vc_next = ovr_vc_reg[OVR_VC_EN_BIT] ? ovr_vc_reg[VC_W-1:0] :
    res_vc_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_out_reg <= '0;
      clock_out_reg <= 8'h00;
      cp_use_reg <= '0;
      va_use_reg <= '0;
      vc_use_reg <= '0;
    end else if (ce) begin
      freq_out_reg <= freq_sel;
      clock_out_reg <= clock_sel;
      cp_use_reg <= cp_next;
      va_use_reg <= va_next;
      vc_use_reg <= vc_next;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (bus.addr)
      ADDR_MAIN: rd_mux = main_reg;
      ADDR_CALIBRATE: rd_mux = cal_reg;
      ADDR_PA_POWER: rd_mux = pa_reg;
      ADDR_OVR_CP: rd_mux = ovr_cp_reg;
      ADDR_OVR_VA: rd_mux = ovr_va_reg;
      ADDR_OVR_VC: rd_mux = ovr_vc_reg;
      ADDR_RES_CP: rd_mux = {4'h0, res_cp_reg};
      ADDR_RES_VA: rd_mux = {3'h0, res_va_reg};
      ADDR_RES_VC: rd_mux = {2'h0, res_vc_reg};
      ADDR_STATUS: begin
        rd_mux[STATUS_CAL_DONE_BIT] = cal_done_reg;
        rd_mux[STATUS_LOCK_BIT] = lock_now;
      end
      default: begin
        if ((bus.addr >= ADDR_SET_A) && (bus.addr <= ADDR_SET_END)) begin
          rd_mux = set_reg[set_idx][byte_idx];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else if (ce) begin
      rd_valid_reg <= bus.rd_en;
      if (bus.rd_en) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.rd_valid = rd_valid_reg;
  assign active_freq = freq_out_reg;
  assign active_clock = clock_out_reg;
  assign rx_tx = main_reg[MAIN_RXTX_BIT];
  assign cal_start = cal_start_reg;
  assign pa_level = pa_reg;
  assign cp_use = cp_use_reg;
  assign va_use = va_use_reg;
  assign vc_use = vc_use_reg;
endmodule

// ---- rtl/hop_host.sv ----
`timescale 1ns/1ns
module hop_host import hop_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  hop_cfg_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_hop,
  input wire logic [CHAN_W-1:0] cmd_chan,
  input wire logic [FREQ_W-1:0] cmd_freq,
  input wire logic [7:0] cmd_clock,
  input wire logic [7:0] pa_on_level,
  output logic done,
  output logic timeout
);
  host_state_e state_reg;
  host_state_e state_next;
  logic [3:0] step_reg;
  logic hop_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [FREQ_W-1:0] freq_reg;
  logic [7:0] clock_reg;
  logic sel_reg;
  logic [7:0] poll_cnt_reg;
  logic [CP_W-1:0] cp_mem [0:(1<<CHAN_W)-1];
  logic [VA_W-1:0] va_mem [0:(1<<CHAN_W)-1];
  logic [VC_W-1:0] vc_shared_reg;
  logic wr_reg;
  logic rd_reg;
  logic [6:0] addr_reg;
  logic [7:0] wdata_reg;
  logic done_reg;
  logic timeout_reg;
  op_kind_e op_kind;
  logic [6:0] op_addr;
  logic [7:0] op_data;
  logic [2:0] op_bit;

  wire [6:0] next_set = sel_reg ? ADDR_SET_A : ADDR_SET_B;
  wire [7:0] main_val = sel_reg ? 8'h00 : 8'h40;

  // Each command is a fixed list of register accesses indexed by step.
  always_comb begin
    op_kind = OP_END;
    op_addr = ADDR_MAIN;
    op_data = 8'h00;
    op_bit = 3'h0;
    if (!hop_reg) begin
      unique case (step_reg)
        4'h0: begin op_kind = OP_WR; op_addr = ADDR_OVR_VA; end
        4'h1: begin op_kind = OP_WR; op_addr = ADDR_OVR_VC; end
        4'h2: begin op_kind = OP_WR; op_addr = next_set | 7'h00; op_data = freq_reg[23:16]; end
        4'h3: begin op_kind = OP_WR; op_addr = next_set | 7'h01; op_data = freq_reg[15:8]; end
        4'h4: begin op_kind = OP_WR; op_addr = next_set | 7'h02; op_data = freq_reg[7:0]; end
        4'h5: begin op_kind = OP_WR; op_addr = next_set | 7'h03; op_data = clock_reg; end
        4'h6: begin op_kind = OP_WR; op_addr = ADDR_MAIN; op_data = main_val; end
        4'h7: begin op_kind = OP_WR; op_addr = ADDR_CALIBRATE; op_data = 8'h80; end
        4'h8: begin
          op_kind = OP_POLL;
          op_addr = ADDR_STATUS;
          op_bit = 3'(STATUS_CAL_DONE_BIT);
        end
        4'h9: begin op_kind = OP_RD; op_addr = ADDR_RES_CP; end
        4'hA: begin op_kind = OP_RD; op_addr = ADDR_RES_VA; end
        4'hB: begin op_kind = OP_RD; op_addr = ADDR_RES_VC; end
        default: op_kind = OP_END;
      endcase
    end else begin
      unique case (step_reg)
        4'h0: begin op_kind = OP_WR; op_addr = ADDR_PA_POWER; end
        4'h1: begin op_kind = OP_WR; op_addr = next_set | 7'h00; op_data = freq_reg[23:16]; end
        4'h2: begin op_kind = OP_WR; op_addr = next_set | 7'h01; op_data = freq_reg[15:8]; end
        4'h3: begin op_kind = OP_WR; op_addr = next_set | 7'h02; op_data = freq_reg[7:0]; end
        4'h4: begin op_kind = OP_WR; op_addr = next_set | 7'h03; op_data = clock_reg; end
        4'h5: begin op_kind = OP_WR; op_addr = ADDR_MAIN; op_data = main_val; end
        4'h6: begin
          op_kind = OP_WR;
          op_addr = ADDR_OVR_CP;
          op_data = {4'h0, cp_mem[chan_reg]};
        end
        4'h7: begin
          op_kind = OP_WR;
          op_addr = ADDR_OVR_VA;
          op_data = {2'b01, 1'b1, va_mem[chan_reg]};
        end
        4'h8: begin
          op_kind = OP_WR;
          op_addr = ADDR_OVR_VC;
          op_data = {2'b01, vc_shared_reg};
        end
        4'h9: begin
          op_kind = OP_POLL;
          op_addr = ADDR_STATUS;
          op_bit = 3'(STATUS_LOCK_BIT);
        end
        4'hA: begin op_kind = OP_WR; op_addr = ADDR_PA_POWER; op_data = pa_on_level; end
        default: op_kind = OP_END;
      endcase
    end
  end

  wire accept = (state_reg == HS_IDLE) && cmd_valid;
  wire poll_ok = bus.rdata[op_bit];
  wire poll_expired = (poll_cnt_reg == POLL_LIMIT);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HS_IDLE: if (cmd_valid) state_next = HS_RUN;
      HS_RUN: begin
        if (op_kind == OP_END) begin
          state_next = HS_IDLE;
        end else if (op_kind != OP_WR) begin
          state_next = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (bus.rd_valid) begin
          state_next = (op_kind == OP_POLL && !poll_ok && poll_expired) ? HS_IDLE : HS_RUN;
        end
      end
      default: state_next = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= HS_IDLE;
      step_reg <= 4'h0;
      hop_reg <= 1'b0;
      chan_reg <= '0;
      freq_reg <= '0;
      clock_reg <= 8'h00;
      sel_reg <= 1'b0;
      poll_cnt_reg <= 8'h00;
      vc_shared_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 7'h00;
      wdata_reg <= 8'h00;
      done_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      if (accept) begin
        hop_reg <= cmd_hop;
        chan_reg <= cmd_chan;
        freq_reg <= cmd_freq;
        clock_reg <= cmd_clock;
        step_reg <= 4'h0;
        poll_cnt_reg <= 8'h00;
        timeout_reg <= 1'b0;
      end
      if (state_reg == HS_RUN) begin
        addr_reg <= op_addr;
        wdata_reg <= op_data;
        if (op_kind == OP_END) begin
          done_reg <= 1'b1;
        end else if (op_kind == OP_WR) begin
          wr_reg <= 1'b1;
          step_reg <= step_reg + 4'h1;
          if (op_addr == ADDR_MAIN) begin
            sel_reg <= !sel_reg;
          end
        end else begin
          rd_reg <= 1'b1;
        end
      end
      if (state_reg == HS_WAIT && bus.rd_valid) begin
        if (op_kind == OP_RD) begin
          step_reg <= step_reg + 4'h1;
          if (op_addr == ADDR_RES_VC) begin
            vc_shared_reg <= bus.rdata[VC_W-1:0];
          end
        end else if (poll_ok) begin
          step_reg <= step_reg + 4'h1;
          poll_cnt_reg <= 8'h00;
        end else if (poll_expired) begin
          timeout_reg <= 1'b1;
          done_reg <= 1'b1;
        end else begin
          poll_cnt_reg <= poll_cnt_reg + 8'h01;
        end
      end
    end
  end

  // The per-channel table stands in for the host's nonvolatile store.
  always_ff @(posedge clk_sys) begin
    if (ce && state_reg == HS_WAIT && bus.rd_valid && op_kind == OP_RD) begin
      if (op_addr == ADDR_RES_CP) begin
        cp_mem[chan_reg] <= bus.rdata[CP_W-1:0];
      end
      if (op_addr == ADDR_RES_VA) begin
        va_mem[chan_reg] <= bus.rdata[VA_W-1:0];
      end
    end
  end

  assign cmd_ready = (state_reg == HS_IDLE);
  assign bus.wr_en = wr_reg;
  assign bus.rd_en = rd_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign done = done_reg;
  assign timeout = timeout_reg;
endmodule

// ---- bench/hop_cfg_chk.sv ----
`timescale 1ns/1ns
module hop_cfg_chk import hop_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  // Shadows are rebuilt from the wire alone, so the host body is never trusted.
  logic sel_reg;
  logic lock_reg;
  logic [6:0] last_wr_reg;
  logic [6:0] rd_addr_reg;
  logic [2:0] en_reg;
  logic [5:0] vc_reg;
  wire main_wr = wr_en && addr == ADDR_MAIN;
  wire lock_rd = rd_valid && rd_addr_reg == ADDR_STATUS && rdata[STATUS_LOCK_BIT];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_reg <= 1'h0;
      lock_reg <= 1'h0;
      last_wr_reg <= 7'h00;
      rd_addr_reg <= 7'h00;
      en_reg <= 3'h0;
      vc_reg <= 6'h00;
    end else begin
      if (wr_en) last_wr_reg <= addr;
      if (main_wr) sel_reg <= wdata[MAIN_SEL_BIT];
      if (wr_en && addr == ADDR_OVR_VA) en_reg[1:0] <= wdata[6:5];
      if (wr_en && addr == ADDR_OVR_VC) en_reg[2] <= wdata[OVR_VC_EN_BIT];
      if (rd_en) rd_addr_reg <= addr;
      if (rd_valid && rd_addr_reg == ADDR_RES_VC) vc_reg <= rdata[5:0];
      if (main_wr) lock_reg <= 1'h0;
      else if (lock_rd) lock_reg <= 1'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_cp;
    wr_en && addr == ADDR_OVR_CP;
  endsequence
  sequence s_va;
    wr_en && addr == ADDR_OVR_VA && wdata[6:5] == 2'h3;
  endsequence
  sequence s_vc;
    wr_en && addr == ADDR_OVR_VC && wdata[OVR_VC_EN_BIT];
  endsequence
  property p_idle_set;
    wr_en && addr >= ADDR_SET_A && addr <= ADDR_SET_END |-> addr[3] != sel_reg;
  endproperty
  property p_sel_swap;
    main_wr |-> wdata[MAIN_SEL_BIT] != sel_reg;
  endproperty
  property p_ovr_seq;
    s_cp |-> ##[1:4] s_va ##[1:4] s_vc;
  endproperty
  property p_sel_first;
    wr_en && addr == ADDR_OVR_CP |-> last_wr_reg == ADDR_MAIN;
  endproperty
  property p_lock_pa;
    wr_en && addr == ADDR_PA_POWER && wdata != 8'h00 |-> lock_reg;
  endproperty
  property p_cal_clear;
    wr_en && addr == ADDR_CALIBRATE && wdata[CAL_START_BIT] |-> en_reg == 3'h0;
  endproperty
  // Only a write that turns the override on replays the stored current; clearing writes carry 00.
  property p_vc_shared;
    s_vc |-> wdata[5:0] == vc_reg;
  endproperty
  property p_rd_answer;
    rd_en && addr == ADDR_STATUS |=> rd_valid;
  endproperty
  property p_rdata_hold;
    !rd_valid |-> $stable(rdata);
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("write to selected set");
  a_sel_swap: assert property (p_sel_swap) else $error("select did not swap");
  a_ovr_seq: assert property (p_ovr_seq) else $error("override order broken");
  a_sel_first: assert property (p_sel_first) else $error("override before select");
  a_lock_pa: assert property (p_lock_pa) else $error("amplifier on before lock");
  a_cal_clear: assert property (p_cal_clear) else $error("enables set at calibrate");
  a_vc_shared: assert property (p_vc_shared) else $error("current not shared");
  a_rd_answer: assert property (p_rd_answer) else $error("status read unanswered");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

// ---- bench/hop_channel_cal_override_tb.sv ----
`timescale 1ns/1ns
module hop_channel_cal_override_tb import hop_pkg::*; ;
  logic clk_sys, rst, cmd_valid, cmd_hop, cmd_ready, done, timeout;
  logic cal_done_in, lock_in, cal_ok, cal_start, rxtx;
  logic [2:0] cal_cnt;
  logic [3:0] cmd_chan, cp_u, cp_b;
  logic [4:0] va_u, va_b;
  logic [5:0] vc_u, vc_b;
  logic [7:0] cmd_clock, act_c, act_cb, pa_lvl, d;
  logic [23:0] cmd_freq, act_f, act_fb;
  int error_cnt = 0;
  int total_checks = 0;
  hop_cfg_if bus(.clk_sys(clk_sys));
  hop_cfg_if bus2(.clk_sys(clk_sys));
  hop_host hop_host_inst(.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .bus(bus.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_hop(cmd_hop), .cmd_chan(cmd_chan),
    .cmd_freq(cmd_freq), .cmd_clock(cmd_clock), .pa_on_level(8'h5A), .done(done),
    .timeout(timeout));
  // Pump and array results follow the tuned frequency; the current result does not.
  hop_device hop_device_inst(.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .bus(bus.device),
    .cal_done_in(cal_done_in), .lock_in(lock_in), .cp_result_in(act_f[3:0]),
    .va_result_in(act_f[8:4]), .vc_result_in(6'h37), .active_freq(act_f),
    .active_clock(act_c), .rx_tx(rxtx), .cal_start(cal_start), .pa_level(pa_lvl), .cp_use(cp_u),
    .va_use(va_u), .vc_use(vc_u));
  // A second device on its own bus lets the register map be probed directly.
  hop_device hop_device_b_inst(.clk_sys(clk_sys), .rst(rst), .ce(1'h1), .bus(bus2.device),
    .cal_done_in(1'h0), .lock_in(lock_in), .cp_result_in(act_f[3:0]),
    .va_result_in(act_f[8:4]), .vc_result_in(act_f[14:9]), .active_freq(act_fb),
    .active_clock(act_cb), .rx_tx(), .cal_start(), .pa_level(), .cp_use(cp_b),
    .va_use(va_b), .vc_use(vc_b));
  hop_cfg_chk hop_cfg_chk_inst(.clk_sys(clk_sys), .rst(rst), .wr_en(bus.wr_en),
    .rd_en(bus.rd_en), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rd_valid(bus.rd_valid));
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cal_start) begin
      cal_done_in <= 1'h0;
      cal_cnt <= 3'h5;
    end else if (cal_cnt != 3'h0) begin
      cal_cnt <= cal_cnt - 3'h1;
      if (cal_cnt == 3'h1) cal_done_in <= cal_ok;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus2.wr_en <= 1'h1;
    bus2.addr <= a;
    bus2.wdata <= v;
    @(posedge clk_sys);
    bus2.wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    int n;
    @(posedge clk_sys);
    bus2.rd_en <= 1'h1;
    bus2.addr <= a;
    @(posedge clk_sys);
    bus2.rd_en <= 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (bus2.rd_valid !== 1'h1 && n < 8);
    v = bus2.rdata;
  endtask
  task automatic rdchk(input string nm, input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(nm, v, exp);
  endtask
  task automatic setw(input logic [6:0] base, input logic [31:0] w);
    for (int i = 0; i < 4; i++) wr(base + 7'(i), w[31-8*i -: 8]);
  endtask
  task automatic cmd(input logic h, input logic [3:0] ch, input logic [31:0] w);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_hop <= h;
    cmd_chan <= ch;
    cmd_freq <= w[31:8];
    cmd_clock <= w[7:0];
    @(posedge clk_sys);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'h1 && n < 4000);
    check("done", done, 1'h1);
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
  end
  initial begin
    rst = 1'h1;
    {cmd_valid, cmd_hop, cmd_chan, cmd_freq, cmd_clock} = '0;
    {bus2.wr_en, bus2.rd_en, bus2.addr, bus2.wdata} = '0;
    {cal_done_in, cal_cnt} = '0;
    lock_in = 1'h1;
    cal_ok = 1'h1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    rdchk("ovr_va", ADDR_OVR_VA, 8'h00);
    setw(ADDR_SET_A, 32'h01020311);
    setw(ADDR_SET_B, 32'h0A0B0C22);
    repeat (2) @(posedge clk_sys);
    check("set_a", {act_fb, act_cb}, 32'h01020311);
    wr(ADDR_MAIN, 8'h40);
    setw(ADDR_SET_A, 32'h04050633);
    check("set_b", {act_fb, act_cb}, 32'h0A0B0C22);
    wr(ADDR_MAIN, 8'h00);
    repeat (2) @(posedge clk_sys);
    check("new_a", {act_fb, act_cb}, 32'h04050633);
    wr(ADDR_OVR_CP, 8'h0A);
    wr(ADDR_OVR_VA, 8'h75);
    wr(ADDR_OVR_VC, 8'h6A);
    repeat (2) @(posedge clk_sys);
    check("forced", {cp_b, va_b, vc_b}, {4'hA, 5'h15, 6'h2A});
    rdchk("ovr_va", ADDR_OVR_VA, 8'h75);
    rdchk("ovr_vc", ADDR_OVR_VC, 8'h6A);
    wr(ADDR_RES_CP, 8'hFF);
    rdchk("res_cp", ADDR_RES_CP, 8'h00);
    rdchk("unmapped", 7'h30, 8'h00);
    rd(ADDR_STATUS, d);
    check("lock", d[STATUS_LOCK_BIT], 1'h1);
    wr(ADDR_SOFT_RESET, 8'h01);
    rdchk("ovr_cp", ADDR_OVR_CP, 8'h00);
    rdchk("ovr_vc", ADDR_OVR_VC, 8'h00);
    check("unforced", {cp_b, act_fb}, 28'h0);
    cmd(1'h0, 4'h1, 32'h12345611);
    check("cal1", {act_f, cp_u, timeout}, {24'h123456, 4'h6, 1'h0});
    check("ready", {cmd_ready, rxtx}, 2'h2);
    cmd(1'h0, 4'h2, 32'hABCDEF22);
    check("cal2", act_f, 24'hABCDEF);
    cal_ok = 1'h0;
    cmd(1'h0, 4'h3, 32'h0F0F0F33);
    check("timeout", timeout, 1'h1);
    cal_ok = 1'h1;
    cmd(1'h1, 4'h1, 32'h12345611);
    check("hop1", {act_f, act_c}, 32'h12345611);
    check("hop1_cal", {cp_u, va_u, vc_u}, {4'h6, 5'h05, 6'h37});
    check("pa", pa_lvl, 8'h5A);
    cmd(1'h1, 4'h2, 32'hABCDEF22);
    check("hop2_cal", {cp_u, va_u, vc_u}, {4'hF, 5'h1E, 6'h37});
    // A calibration after a hop must drop the forced values and use fresh results.
    cmd(1'h0, 4'h4, 32'h13579B44);
    check("recal", {cp_u, va_u, vc_u}, {4'hB, 5'h19, 6'h37});
    wrap_up();
  end
endmodule
